// File: design/ihp_acc_if.sv
// access events from the pin front end to the port core
`timescale 1ns/100ps
interface ihp_acc_if;
    logic        wr_evt;
    logic        rd_start;
    logic        rd_end;
    logic        is_cmd;
    logic        lane_lo;
    logic        lane_hi;
    logic [15:0] data;
    logic        mode_n;
    logic        endian;
    logic        indirect;

    modport front (
        output wr_evt, rd_start, rd_end, is_cmd, lane_lo, lane_hi,
        output data, mode_n, endian, indirect
    );
    modport core (
        input wr_evt, rd_start, rd_end, is_cmd, lane_lo, lane_hi,
        input data, mode_n, endian, indirect
    );
endinterface

// File: design/ihp_mode80_port.sv
// mode 80 indirect host port core
// Function
// - byte and word, both endian orders
// - command register number from low lane
// - byte register access on either lane, even or odd
// - word access low lane lower register
// - start command turns data into burst
// - byte burst access steps pointer one
// - word burst access steps pointer two
// - word select makes writes full words
// - word select makes reads full words
// - endian order only for word memory
// - fixed clock count per bus cycle
// - oscillator only with indirect interface
// - oscillator runs on its enable bits
// - mode chosen from bus select level
// - seventeen bit pointer into display buffer
`timescale 1ns/100ps
`include "ihp_params.svh"
module ihp_mode80_port (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [15:0] host_data_in,
    output logic      [15:0] host_data_out,
    output logic             host_data_oe,
    input  wire logic        cmd_select,
    input  wire logic        chip_select_n,
    input  wire logic        upper_write_strobe_n,
    input  wire logic        lower_write_strobe_n,
    input  wire logic        upper_read_strobe_n,
    input  wire logic        lower_read_strobe_n,
    input  wire logic        bus_mode_select_n,
    input  wire logic        endian_strap,
    input  wire logic        indirect_select,
    input  wire logic [15:0] mem_rdata,
    output logic      [15:0] mem_addr,
    output logic      [15:0] mem_wdata,
    output logic             mem_we_lo,
    output logic             mem_we_hi,
    output logic             mem_re,
    output logic             crystal_osc_enable,
    output logic             clock_from_crystal,
    output logic             mode80_active
);
    import ihp_pkg::*;

    ihp_core_t  q;
    ihp_core_t  d;
    ihp_pins_t  pins;
    ihp_acc_if  acc ();
    logic       wr_ok;
    logic       rd_ok;
    logic       mem_word;
    logic       mem_byte;
    logic [7:0] pair_base;
    logic [7:0] byte_val;

    // one driver for the whole pin bundle
    always_comb
    begin
        pins.data = host_data_in;
        pins.cmd_sel = cmd_select;
        pins.cs_n = chip_select_n;
        pins.upper_write_strobe_n = upper_write_strobe_n;
        pins.lower_write_strobe_n = lower_write_strobe_n;
        pins.upper_read_strobe_n = upper_read_strobe_n;
        pins.lower_read_strobe_n = lower_read_strobe_n;
        pins.mode_n = bus_mode_select_n;
        pins.endian = endian_strap;
        pins.indirect = indirect_select;
    end

    ihp_pin_front u_front (
        .clock (clock),
        .reset (reset),
        .pins  (pins),
        .acc   (acc)
    );

    function automatic logic [7:0] reg_rd(ihp_core_t s, logic [7:0] idx);
        logic [7:0] v;
        v = 8'h00;
        case (idx)
            `IHP_REG_PTR0:   v = s.ptr[7:0];
            `IHP_REG_PTR1:   v = s.ptr[15:8];
            `IHP_REG_PTR2:   v = {7'h00, s.ptr[16]};
            `IHP_REG_WSEL:   v = s.wsel;
            `IHP_REG_CLKSRC: v = s.clksrc;
            default:         v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic ihp_core_t reg_wr(ihp_core_t s, logic [7:0] idx,
                                         logic [7:0] v);
        ihp_core_t r;
        r = s;
        case (idx)
            `IHP_REG_PTR0:   r.ptr[7:0] = v;
            `IHP_REG_PTR1:   r.ptr[15:8] = v;
            `IHP_REG_PTR2:   r.ptr[16] = v[0];
            `IHP_REG_WSEL:   r.wsel = v;
            `IHP_REG_CLKSRC: r.clksrc = v;
            default:         r = s;
        endcase
        return r;
    endfunction

    // the core is little endian inside, big endian swaps word lanes
    function automatic logic [15:0] mem_order(logic be, logic [15:0] w);
        return be ? {w[7:0], w[15:8]} : w;
    endfunction

    // port acts only in this mode
    assign wr_ok = q.mode80 & acc.wr_evt;
    assign rd_ok = q.mode80 & acc.rd_start;
    // word select ignores the upper strobe
    assign mem_word = q.wsel[`IHP_WSEL_BIT] ? acc.lane_lo
                                           : (acc.lane_lo & acc.lane_hi);
    assign mem_byte = ~q.wsel[`IHP_WSEL_BIT] & (acc.lane_lo ^ acc.lane_hi);
    // pair base is the even register
    assign pair_base = {q.reg_num[7:1], 1'b0};
    // odd register may use either lane
    assign byte_val = acc.lane_hi ? acc.data[15:8] : acc.data[7:0];

    always_comb
    begin
        d = q;
        d.mem_we_lo = 1'b0;
        d.mem_we_hi = 1'b0;
        d.mem_re = 1'b0;
        // bus select level picks this mode
        d.mode80 = (acc.mode_n == `IHP_MODE80_LEVEL);
        // strap taken once the synchroniser has filled
        if (q.strap_cnt != `IHP_STRAP_WAIT)
        begin
            d.strap_cnt = q.strap_cnt + 2'h1;
            d.big_endian = acc.endian;
        end
        // both enable bits start the oscillator while the indirect select is high
        d.osc_en = acc.indirect & q.clksrc[`IHP_OSC_HI_BIT]
                   & q.clksrc[`IHP_OSC_LO_BIT];
        d.crystal_src = q.clksrc[`IHP_CRYSTAL_SRC_BIT];

        if (wr_ok)
        begin
            if (acc.is_cmd)
            begin
                d.reg_num = acc.data[7:0];
                d.burst = (acc.data[7:0] == `IHP_REG_START);
            end
            else if (q.burst)
            begin
                d.mem_addr = q.ptr[16:1];
                if (mem_word)
                begin
                    d.mem_wdata = mem_order(q.big_endian, acc.data);
                    d.mem_we_lo = 1'b1;
                    d.mem_we_hi = 1'b1;
                    d.ptr = q.ptr + `IHP_STEP_WORD;
                end
                else if (mem_byte)
                begin
                    // byte lands the same in both orders
                    d.mem_wdata = {byte_val, byte_val};
                    d.mem_we_lo = ~q.ptr[0];
                    d.mem_we_hi = q.ptr[0];
                    d.ptr = q.ptr + `IHP_STEP_BYTE;
                end
            end
            else if (acc.lane_lo & acc.lane_hi)
            begin
                d = reg_wr(d, pair_base, acc.data[7:0]);
                d = reg_wr(d, {pair_base[7:1], 1'b1}, acc.data[15:8]);
            end
            else
            begin
                // single byte from the lane used
                d = reg_wr(d, q.reg_num, byte_val);
            end
        end

        if (rd_ok)
        begin
            d.doe = 1'b1;
            d.rd_mem = 1'b0;
            if (acc.is_cmd)
            begin
                d.dout = {8'h00, q.reg_num};
            end
            else if (q.burst)
            begin
                if (mem_word | mem_byte)
                begin
                    d.mem_addr = q.ptr[16:1];
                    d.mem_re = 1'b1;
                    d.rd_word = mem_word;
                    d.rd_mem = 1'b1;
                end
            end
            else if (acc.lane_lo & acc.lane_hi)
            begin
                // pair read, lower register on low lane
                d.dout = {reg_rd(q, {pair_base[7:1], 1'b1}),
                          reg_rd(q, pair_base)};
            end
            else
            begin
                d.dout = {reg_rd(q, q.reg_num), reg_rd(q, q.reg_num)};
            end
        end

        // buffer data two cycles after the read start
        if (q.mem_re)
        begin
            d.rd_wait = 1'b1;
        end
        if (q.rd_wait)
        begin
            d.rd_wait = 1'b0;
            if (q.rd_word)
            begin
                d.dout = mem_order(q.big_endian, mem_rdata);
            end
            else if (q.ptr[0])
            begin
                d.dout = {mem_rdata[15:8], mem_rdata[15:8]};
            end
            else
            begin
                d.dout = {mem_rdata[7:0], mem_rdata[7:0]};
            end
        end

        // pointer moves at the end so the data read stays at its address
        if (acc.rd_end)
        begin
            d.doe = 1'b0;
            d.rd_mem = 1'b0;
            if (q.rd_mem)
            begin
                d.ptr = q.ptr + (q.rd_word ? `IHP_STEP_WORD : `IHP_STEP_BYTE);
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            q <= '0;
            q.wsel <= `IHP_WSEL_RST;
            q.clksrc <= `IHP_CLKSRC_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign host_data_out = q.dout;
    assign host_data_oe = q.doe;
    assign mem_addr = q.mem_addr;
    assign mem_wdata = q.mem_wdata;
    assign mem_we_lo = q.mem_we_lo;
    assign mem_we_hi = q.mem_we_hi;
    assign mem_re = q.mem_re;
    assign crystal_osc_enable = q.osc_en;
    assign clock_from_crystal = q.crystal_src;
    assign mode80_active = q.mode80;

    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (reset);

    AST_CMD_LANE: assert property (
        wr_ok && acc.is_cmd |=> q.reg_num == $past(acc.data[7:0]))
        else $error("command number not taken from low lane");

    AST_MODE_GATE: assert property (
        acc.wr_evt && !q.mode80 |=> $stable(q.reg_num) && $stable(q.ptr))
        else $error("access acted on outside mode 80");

    AST_BURST_ON: assert property (
        wr_ok && acc.is_cmd && acc.data[7:0] == `IHP_REG_START
        |=> q.burst)
        else $error("start command did not arm burst");

    AST_BURST_END: assert property (
        wr_ok && acc.is_cmd && acc.data[7:0] != `IHP_REG_START
        |=> !q.burst)
        else $error("command write left burst armed");

    AST_REG_PAIR: assert property (
        wr_ok && !acc.is_cmd && !q.burst && acc.lane_lo && acc.lane_hi
        && q.reg_num == `IHP_REG_PTR0
        |=> q.ptr[15:0] == $past(acc.data))
        else $error("word register write lanes swapped");

    AST_BYTE_STEP: assert property (
        wr_ok && !acc.is_cmd && q.burst && mem_byte
        |=> q.ptr == $past(q.ptr) + `IHP_STEP_BYTE)
        else $error("byte burst did not step pointer by one");

    AST_WORD_STEP: assert property (
        wr_ok && !acc.is_cmd && q.burst && mem_word
        |=> q.ptr == $past(q.ptr) + `IHP_STEP_WORD)
        else $error("word burst did not step pointer by two");

    AST_WSEL_WR: assert property (
        wr_ok && !acc.is_cmd && q.burst && q.wsel[`IHP_WSEL_BIT]
        && acc.lane_lo |=> q.mem_we_lo && q.mem_we_hi)
        else $error("word select write was not a full word");

    AST_WSEL_RD: assert property (
        rd_ok && !acc.is_cmd && q.burst && q.wsel[`IHP_WSEL_BIT]
        && acc.lane_lo |=> q.mem_re && q.rd_word)
        else $error("word select read was not a full word");

    AST_BYTE_PLACE: assert property (
        wr_ok && !acc.is_cmd && q.burst && mem_byte && acc.lane_lo
        |=> q.mem_wdata == {2{$past(acc.data[7:0])}})
        else $error("byte write placement depends on order");

    AST_LE_WORD: assert property (
        wr_ok && !acc.is_cmd && q.burst && mem_word && !q.big_endian
        |=> q.mem_wdata == $past(acc.data))
        else $error("little endian word reordered");

    AST_RD_LAT: assert property (
        rd_ok && !acc.is_cmd && q.burst && (mem_word || mem_byte)
        |=> q.mem_re ##1 q.rd_wait ##1 !q.rd_wait)
        else $error("memory read latency off");

    AST_OSC_GATE: assert property (
        q.osc_en == ($past(acc.indirect)
                     && $past(q.clksrc[`IHP_OSC_HI_BIT])
                     && $past(q.clksrc[`IHP_OSC_LO_BIT])))
        else $error("oscillator state differs from its enables");
endmodule

// File: design/ihp_params.svh
// offsets, field positions, reset values and counts of the host port
`ifndef IHP_PARAMS_SVH
`define IHP_PARAMS_SVH

`define IHP_REG_PTR0      8'hC0
`define IHP_REG_PTR1      8'hC1
`define IHP_REG_PTR2      8'hC2
`define IHP_REG_START     8'hC4
`define IHP_REG_WSEL      8'hC6
`define IHP_REG_CLKSRC    8'hCA

`define IHP_WSEL_BIT      0
`define IHP_OSC_LO_BIT    4
`define IHP_OSC_HI_BIT    5
`define IHP_CRYSTAL_SRC_BIT 0

`define IHP_WSEL_RST      8'h00
`define IHP_CLKSRC_RST    8'h00

`define IHP_MODE80_LEVEL  1'b1
`define IHP_STRAP_WAIT    2'h3
`define IHP_STEP_BYTE     17'h00001
`define IHP_STEP_WORD     17'h00002

`endif

// File: design/ihp_pin_front.sv
// pin synchroniser and strobe edge detector of the host port
`timescale 1ns/100ps
module ihp_pin_front (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire ihp_pkg::ihp_pins_t pins,
    ihp_acc_if.front               acc
);
    import ihp_pkg::*;

    ihp_front_t q;
    ihp_front_t d;

    always_comb
    begin
        d = q;
        d.s1 = pins;
        d.s2 = q.s1;
        // only the second stage is looked at
        d.wr_low = ~q.s2.cs_n & ~(q.s2.lower_write_strobe_n
                                  & q.s2.upper_write_strobe_n);
        d.rd_low = ~q.s2.cs_n & ~(q.s2.lower_read_strobe_n
                                  & q.s2.upper_read_strobe_n);
        d.wr_evt = q.wr_low & ~d.wr_low;
        d.rd_start = d.rd_low & ~q.rd_low;
        d.rd_end = q.rd_low & ~d.rd_low;
        // lanes gather over the whole strobe, skew between write strobes is fine, a read takes the lanes seen at its start
        if (d.wr_low)
        begin
            d.lane_lo = q.lane_lo | ~q.s2.lower_write_strobe_n;
            d.lane_hi = q.lane_hi | ~q.s2.upper_write_strobe_n;
            d.data = q.s2.data;
        end
        else if (d.rd_low)
        begin
            d.lane_lo = q.lane_lo | ~q.s2.lower_read_strobe_n;
            d.lane_hi = q.lane_hi | ~q.s2.upper_read_strobe_n;
        end
        else
        begin
            d.lane_lo = 1'b0;
            d.lane_hi = 1'b0;
        end
        if (d.wr_evt)
        begin
            d.o_lo = q.lane_lo;
            d.o_hi = q.lane_hi;
            d.o_data = q.data;
            d.o_cmd = q.s2.cmd_sel;
        end
        else if (d.rd_start)
        begin
            d.o_lo = d.lane_lo;
            d.o_hi = d.lane_hi;
            d.o_cmd = q.s2.cmd_sel;
        end
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            q <= '0;
            q.s1 <= '1;
            q.s2 <= '1;
        end
        else
        begin
            q <= d;
        end
    end

    assign acc.wr_evt = q.wr_evt;
    assign acc.rd_start = q.rd_start;
    assign acc.rd_end = q.rd_end;
    assign acc.is_cmd = q.o_cmd;
    assign acc.lane_lo = q.o_lo;
    assign acc.lane_hi = q.o_hi;
    assign acc.data = q.o_data;
    assign acc.mode_n = q.s2.mode_n;
    assign acc.endian = q.s2.endian;
    assign acc.indirect = q.s2.indirect;
endmodule

// File: design/ihp_pkg.sv
// state types of the indirect host port
package ihp_pkg;

    typedef struct packed {
        logic [15:0] data;
        logic        cmd_sel;
        logic        cs_n;
        logic        upper_write_strobe_n;
        logic        lower_write_strobe_n;
        logic        upper_read_strobe_n;
        logic        lower_read_strobe_n;
        logic        mode_n;
        logic        endian;
        logic        indirect;
    } ihp_pins_t;

    typedef struct packed {
        ihp_pins_t   s1;
        ihp_pins_t   s2;
        logic        wr_low;
        logic        rd_low;
        logic        lane_lo;
        logic        lane_hi;
        logic [15:0] data;
        logic        wr_evt;
        logic        rd_start;
        logic        rd_end;
        logic        o_cmd;
        logic        o_lo;
        logic        o_hi;
        logic [15:0] o_data;
    } ihp_front_t;

    typedef struct packed {
        logic [7:0]  reg_num;
        logic [16:0] ptr;
        logic        burst;
        logic [7:0]  wsel;
        logic [7:0]  clksrc;
        logic        big_endian;
        logic [1:0]  strap_cnt;
        logic        rd_word;
        logic        rd_mem;
        logic        rd_wait;
        logic [15:0] dout;
        logic        doe;
        logic [15:0] mem_addr;
        logic [15:0] mem_wdata;
        logic        mem_we_lo;
        logic        mem_we_hi;
        logic        mem_re;
        logic        osc_en;
        logic        crystal_src;
        logic        mode80;
    } ihp_core_t;

endpackage

// File: verif/ihp_host_model.sv
// host cpu model driving the shared command and data bus
`timescale 1ns/100ps
module ihp_host_model (
    input  wire logic        clock,
    output logic      [15:0] host_data_in,
    output logic             cmd_select,
    output logic             chip_select_n,
    output logic             upper_write_strobe_n,
    output logic             lower_write_strobe_n,
    output logic             upper_read_strobe_n,
    output logic             lower_read_strobe_n,
    input  wire logic [15:0] host_data_out
);
    initial
    begin
        host_data_in = 16'h0000;
        cmd_select = 1'b0;
        chip_select_n = 1'b1;
        upper_write_strobe_n = 1'b1;
        lower_write_strobe_n = 1'b1;
        upper_read_strobe_n = 1'b1;
        lower_read_strobe_n = 1'b1;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // host side
    // cycle counts stretched well past the port's needs
    task automatic wr(input logic c, input logic [15:0] d,
                      input logic lo, input logic hi);
        step(1);
        cmd_select = c;
        host_data_in = d;
        chip_select_n = 1'b0;
        lower_write_strobe_n = !lo;
        upper_write_strobe_n = !hi;
        step(4);
        lower_write_strobe_n = 1'b1;
        upper_write_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        step(4);
        // released bus shows no stale value
        host_data_in = ~d;
        step(4);
    endtask

    task automatic rd(input logic lo, input logic hi,
                      output logic [15:0] q);
        step(1);
        cmd_select = 1'b0;
        chip_select_n = 1'b0;
        lower_read_strobe_n = !lo;
        upper_read_strobe_n = !hi;
        step(9);
        q = host_data_out;
        lower_read_strobe_n = 1'b1;
        upper_read_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        step(6);
    endtask
endmodule

// File: verif/testbench.sv
// self-checking bench of the mode 80 host port
`timescale 1ns/100ps
`include "ihp_params.svh"
module testbench;
    import ihp_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic        mode_n = 1'b1;
    logic        strap = 1'b0;
    logic        ind_sel = 1'b1;
    logic [15:0] host_data_in, host_data_out, mem_addr, mem_wdata;
    logic [15:0] mem_rdata = 16'h0000;
    logic [15:0] rd_val = 16'h0000;
    logic [15:0] wa, wd, ra, q;
    logic [1:0]  wm;
    logic        oe, cmd_sel, cs_n, up_wr_n, lo_wr_n, up_rd_n, lo_rd_n;
    logic        we_lo, we_hi, mem_re, osc_en, crystal, m80;
    logic        oe_seen = 1'b0;
    int          fail_count = 0;
    int          checks_done = 0;

    always #5 clock = ~clock;

    // buffer model: data the cycle after mem_re, changing otherwise
    always @(posedge clock)
    begin
        mem_rdata <= mem_re ? rd_val : ~mem_rdata;
        if (mem_re)
            ra <= mem_addr;
        if (oe)
            oe_seen <= 1'b1;
        if (we_lo | we_hi)
        begin
            wa <= mem_addr;
            wd <= mem_wdata;
            wm <= {we_hi, we_lo};
        end
    end

    ihp_host_model ihp_host_model_i (
        .clock(clock), .host_data_in(host_data_in), .cmd_select(cmd_sel),
        .chip_select_n(cs_n), .upper_write_strobe_n(up_wr_n),
        .lower_write_strobe_n(lo_wr_n), .upper_read_strobe_n(up_rd_n),
        .lower_read_strobe_n(lo_rd_n), .host_data_out(host_data_out));

    ihp_mode80_port ihp_mode80_port_i (
        .clock(clock), .reset(reset), .host_data_in(host_data_in),
        .host_data_out(host_data_out), .host_data_oe(oe),
        .cmd_select(cmd_sel), .chip_select_n(cs_n),
        .upper_write_strobe_n(up_wr_n), .lower_write_strobe_n(lo_wr_n),
        .upper_read_strobe_n(up_rd_n), .lower_read_strobe_n(lo_rd_n),
        .bus_mode_select_n(mode_n), .endian_strap(strap),
        .indirect_select(ind_sel), .mem_rdata(mem_rdata),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we_lo(we_lo),
        .mem_we_hi(we_hi), .mem_re(mem_re), .crystal_osc_enable(osc_en),
        .clock_from_crystal(crystal), .mode80_active(m80));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic do_reset(input logic big);
        @(posedge clock);
        #1;
        reset = 1'b1;
        strap = big;
        repeat (10) @(posedge clock);
        #1;
        reset = 1'b0;
        repeat (5) @(posedge clock);
        #1;
    endtask

    task automatic cmd(input logic [7:0] n);
        ihp_host_model_i.wr(1'b1, {8'h00, n}, 1'b1, 1'b0);
    endtask

    task automatic reg_wr(input logic [7:0] n, input logic [15:0] d,
                          input logic lo, input logic hi);
        cmd(n);
        ihp_host_model_i.wr(1'b0, d, lo, hi);
    endtask

    task automatic reg_rd(input logic [7:0] n, input logic lo,
                          input logic hi, output logic [15:0] v);
        cmd(n);
        ihp_host_model_i.rd(lo, hi, v);
    endtask

    task automatic set_ptr(input logic [16:0] p);
        reg_wr(`IHP_REG_PTR0, p[15:0], 1'b1, 1'b1);
        reg_wr(`IHP_REG_PTR2, {15'h0000, p[16]}, 1'b1, 1'b0);
        cmd(`IHP_REG_START);
        wm = 2'h0;
    endtask

    task automatic t_reset();
        chk(oe, 1'b0);
        chk(osc_en, 1'b0);
        chk(crystal, 1'b0);
        reg_rd(`IHP_REG_WSEL, 1'b1, 1'b0, q);
        chk(q, 16'h0000);
        reg_rd(`IHP_REG_CLKSRC, 1'b1, 1'b0, q);
        chk(q, 16'h0000);
        reg_wr(8'h10, 16'h5555, 1'b1, 1'b1);
        reg_rd(8'h10, 1'b1, 1'b1, q);
        chk(q, 16'h0000);
    endtask

    task automatic t_regs();
        reg_wr(`IHP_REG_PTR0, 16'h1234, 1'b1, 1'b1);
        reg_rd(`IHP_REG_PTR0, 1'b1, 1'b0, q);
        chk(q, 16'h3434);
        reg_rd(`IHP_REG_PTR1, 1'b0, 1'b1, q);
        chk(q, 16'h1212);
        reg_wr(`IHP_REG_PTR1, 16'h0056, 1'b1, 1'b0);
        reg_rd(`IHP_REG_PTR0, 1'b1, 1'b1, q);
        chk(q, 16'h5634);
        reg_wr(`IHP_REG_PTR1, 16'h7700, 1'b0, 1'b1);
        reg_rd(`IHP_REG_PTR0, 1'b1, 1'b1, q);
        chk(q, 16'h7734);
    endtask

    task automatic t_word_burst();
        set_ptr(17'h00100);
        ihp_host_model_i.wr(1'b0, 16'hABCD, 1'b1, 1'b1);
        chk({14'h0, wm}, 16'h0003);
        chk(wa, 16'h0080);
        chk(wd, 16'hABCD);
        ihp_host_model_i.wr(1'b0, 16'h1357, 1'b1, 1'b1);
        chk(wa, 16'h0081);
        oe_seen = 1'b0;
        rd_val = 16'h2468;
        ihp_host_model_i.rd(1'b1, 1'b1, q);
        chk(q, 16'h2468);
        chk(ra, 16'h0082);
        chk({15'h0000, oe_seen}, 16'h0001);
        chk(oe, 1'b0);
        reg_rd(`IHP_REG_PTR0, 1'b1, 1'b1, q);
        chk(q, 16'h0106);
    endtask

    task automatic t_byte_burst();
        set_ptr(17'h10005);
        ihp_host_model_i.wr(1'b0, 16'h0077, 1'b1, 1'b0);
        chk({14'h0, wm}, 16'h0002);
        chk(wa, 16'h8002);
        chk(wd[15:8], 8'h77);
        ihp_host_model_i.wr(1'b0, 16'h0088, 1'b1, 1'b0);
        chk({14'h0, wm}, 16'h0001);
        chk(wa, 16'h8003);
        chk(wd[7:0], 8'h88);
        rd_val = 16'h5A3C;
        ihp_host_model_i.rd(1'b1, 1'b0, q);
        chk(q, 16'h5A5A);
        reg_rd(`IHP_REG_PTR2, 1'b1, 1'b0, q);
        chk(q, 16'h0101);
        reg_rd(`IHP_REG_PTR0, 1'b1, 1'b1, q);
        chk(q, 16'h0008);
    endtask

    task automatic t_wsel();
        reg_wr(`IHP_REG_WSEL, 16'h0001, 1'b1, 1'b0);
        set_ptr(17'h00200);
        ihp_host_model_i.wr(1'b0, 16'h4321, 1'b0, 1'b1);
        chk({14'h0, wm}, 16'h0000);
        ihp_host_model_i.wr(1'b0, 16'h4321, 1'b1, 1'b0);
        chk({14'h0, wm}, 16'h0003);
        chk(wa, 16'h0100);
        chk(wd, 16'h4321);
        rd_val = 16'hBEEF;
        ihp_host_model_i.rd(1'b1, 1'b0, q);
        chk(q, 16'hBEEF);
        chk(ra, 16'h0101);
        reg_wr(`IHP_REG_WSEL, 16'h0000, 1'b1, 1'b0);
    endtask

    task automatic t_big();
        do_reset(1'b1);
        set_ptr(17'h00000);
        ihp_host_model_i.wr(1'b0, 16'hABCD, 1'b1, 1'b1);
        chk(wd, 16'hCDAB);
        rd_val = 16'h1234;
        ihp_host_model_i.rd(1'b1, 1'b1, q);
        chk(q, 16'h3412);
        ihp_host_model_i.wr(1'b0, 16'h0011, 1'b1, 1'b0);
        chk({14'h0, wm}, 16'h0001);
        chk(wd[7:0], 8'h11);
        chk(wa, 16'h0002);
        do_reset(1'b0);
    endtask

    task automatic t_osc();
        mode_n = 1'b0;
        reg_wr(`IHP_REG_CLKSRC, 16'h0031, 1'b1, 1'b0);
        chk(m80, 1'b0);
        mode_n = 1'b1;
        repeat (8) @(posedge clock);
        #1;
        chk(m80, 1'b1);
        reg_rd(`IHP_REG_CLKSRC, 1'b1, 1'b0, q);
        chk(q, 16'h0000);
        reg_wr(`IHP_REG_CLKSRC, 16'h0031, 1'b1, 1'b0);
        chk(osc_en, 1'b1);
        chk(crystal, 1'b1);
        ind_sel = 1'b0;
        repeat (8) @(posedge clock);
        #1;
        chk(osc_en, 1'b0);
        ind_sel = 1'b1;
        reg_wr(`IHP_REG_CLKSRC, 16'h0011, 1'b1, 1'b0);
        chk(osc_en, 1'b0);
    endtask

    // a full run is about a thousand cycles
    initial
    begin
        #400000;
        fail_count++;
        complete_run();
    end

    initial
    begin
        do_reset(1'b0);
        t_reset();
        t_regs();
        t_word_burst();
        t_byte_burst();
        t_wsel();
        t_big();
        t_osc();
        complete_run();
    end
endmodule
